// ==== core/tgmac_tx.sv ====
// transmit client path of a 10G mac plus receive fcs check and strip
// assumes apb master, client stream and rx engine all on core_clk
//
// How it works
// - fcs bits leave x31 first: reflected crc, inverted, low byte first
// - config bit picks inserted fcs or client supplied in-band fcs
// - every received frame crc checked, tuser low on mismatch
// - config bit forwards received fcs bytes or strips them
// - gap counted from terminate, stream held off until it is met
// - start placed on next four byte lane boundary, later if extended
// - deficit idle averaging may shorten gaps, mean stays at the requested gap
// - data bus is eight byte lanes each qualified by its keep bit
// - last marks final beat, unkept bytes ignored
// - custom preamble beat is taken with ready before the frame
// - without in-band fcs short frames padded to minimum length
// - with in-band fcs short frames terminated but never padded
// - in-band short frames are not counted in statistics
// - tuser with valid mid-frame aborts as underrun
// - valid falling mid-frame without last is an implicit underrun
// - underrun sends error codes then returns to idle
// - valid may stay high across frames, ready withheld for gap
// - eight bit gap extension input sets requested gap in columns
// - with gap adjust, ready held off until requested columns pass
// - gap never below three columns, nine bytes with averaging, whatever the extension value
// - fcs is crc32 over addresses, type, data and pad
module tgmac_tx #(
	parameter int CNT_W = 16
) (
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire tgmac_pkg::tgmac_beat_type tx_in,
	output logic                          tx_ready,
	input  wire logic [7:0]               ifg_delay,
	output tgmac_pkg::tgmac_xgmii_type    xgmii_tx,
	input  wire tgmac_pkg::tgmac_beat_type rx_in,
	output tgmac_pkg::tgmac_beat_type     rx_out
);
	import tgmac_pkg::*;

	if (CNT_W < 1 || CNT_W > 16) begin : g_chk
		$error("CNT_W must be 1 to 16");
	end

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	// crc over the kept byte lanes, lsb of each byte first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [63:0] d, input logic [7:0] m);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < LANES; i++)
			for (int b = 0; b < 8; b++)
				if (m[i])
					r = (r >> 1) ^ ((r[0] ^ d[8*i+b]) ? CRC_POLY : 32'h0);
		return r;
	endfunction

	// number of kept lanes
	function automatic logic [3:0] count_keep(input logic [7:0] k);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < LANES; i++)
			n = n + {3'h0, k[i]};
		return n;
	endfunction

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// -------------------------------------------------------------
	// apb slave
	// -------------------------------------------------------------
	logic [CFG_W-1:0] cfg;
	logic [CNT_W-1:0] tx_count;
	logic [CNT_W-1:0] rx_bad;
	logic             setup;
	logic             hit_cfg;
	logic             hit_stat;
	logic [31:0]      rd_word;

	// decode and read select
	assign setup = psel && !penable;
	assign hit_cfg = paddr == CFG_ADDR;
	assign hit_stat = paddr == STAT_ADDR;
	assign rd_word = hit_cfg ? 32'(cfg)
		: hit_stat ? {16'(rx_bad), 16'(tx_count)} : 32'h0;

	// answer in the first access cycle, writes land there
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
			cfg <= CFG_RESET;
		end else begin
			pready <= setup;
			prdata <= (setup && !pwrite) ? rd_word : 32'h0;
			pslverr <= setup && !(hit_cfg || hit_stat);
			if (psel && penable && pready && pwrite && hit_cfg)
				cfg <= pwdata[CFG_W-1:0];
		end
	end

	logic inband;
	logic dic_en;
	logic gap_adj;
	logic rx_pass;
	logic cust;
	assign inband = cfg[CFG_TX_INBAND];
	assign dic_en = cfg[CFG_DIC];
	assign gap_adj = cfg[CFG_GAP_ADJ];
	assign rx_pass = cfg[CFG_RX_PASS];
	assign cust = cfg[CFG_CUST_PRE];

	// -------------------------------------------------------------
	// transmit framing
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		S_GAP  = 4'b0001,
		S_PRE  = 4'b0010,
		S_DATA = 4'b0100,
		S_TAIL = 4'b1000
	} tgmac_state_type;

	tgmac_state_type state;
	tgmac_state_type next_state;
	logic [15:0] base;
	logic [15:0] len;
	logic [31:0] crc;
	logic [11:0] acc;
	logic        shift;
	logic [1:0]  deficit_idle_averaging;
	logic [1:0]  next_dic;
	logic [31:0] hold_d;
	logic [3:0]  hold_c;

	logic        data_ph;
	logic        abort;
	logic [15:0] flen;
	logic [15:0] padl;
	logic [15:0] fcs_end;
	logic [15:0] tdist;
	logic        t_here;
	logic [63:0] pd;
	logic [7:0]  mask;
	logic [31:0] crc_mid;
	logic [31:0] fcs;
	logic [63:0] fw_d;
	logic [7:0]  fw_c;
	logic [63:0] aw_d;
	logic [7:0]  aw_c;

	// length and tail positions of the current frame
	assign data_ph = state == S_DATA;
	assign abort = data_ph && (!tx_in.valid || tx_in.user);
	assign flen = data_ph ? base + 16'(count_keep(tx_in.keep)) : len;
	assign padl = (!inband && flen < MIN_NOFCS) ? MIN_NOFCS : flen;
	assign fcs_end = inband ? padl : padl + FCS_BYTES;
	assign tdist = fcs_end - base;
	assign t_here = ((data_ph && !abort && tx_in.last) || state == S_TAIL)
		&& tdist < 16'h0008;

	// crc over data and pad, fcs inverted, low byte first
	assign crc_mid = crc_step(crc, pd, mask);
	assign fcs = ~crc_mid;

	// per lane: data, pad, fcs, terminate or idle
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [15:0] idx;
		logic [1:0]  k;
		logic        is_fcs;
		logic        is_term;
		logic        is_idle;
		assign idx = base + 16'(i);
		assign k = 2'(idx - padl);
		assign pd[8*i +: 8] = (data_ph && idx < flen)
			? tx_in.data[8*i +: 8] : 8'h00;
		assign mask[i] = (data_ph || state == S_TAIL) && idx < padl;
		assign is_fcs = !inband && idx >= padl && idx < fcs_end;
		assign is_term = idx == fcs_end;
		assign is_idle = idx > fcs_end;
		assign fw_d[8*i +: 8] = is_term ? XG_TERM : is_idle ? XG_IDLE
			: is_fcs ? fcs[8*k +: 8] : pd[8*i +: 8];
		assign fw_c[i] = is_term || is_idle;
	end

	// aligned word for this cycle
	always_comb begin
		aw_d = {8{XG_IDLE}};
		aw_c = 8'hff;
		case (state)
			S_PRE: begin
				if (cust && !tx_in.valid) begin
					aw_d = ERR_DATA;
				end else begin
					aw_d = {cust ? tx_in.data[63:8]
						: {SFD_BYTE, {6{PRE_BYTE}}}, XG_START};
					aw_c = 8'h01;
				end
			end
			S_DATA: begin
				if (abort) begin
					aw_d = ERR_DATA;
				end else begin
					aw_d = fw_d;
					aw_c = fw_c;
				end
			end
			S_TAIL: begin
				aw_d = fw_d;
				aw_c = fw_c;
			end
			default: begin
				aw_d = {8{XG_IDLE}};
				aw_c = 8'hff;
			end
		endcase
	end

	// gap check: requested gap, averaging slack, lane choice
	logic [12:0] gbase;
	logic [12:0] ext;
	logic [12:0] req;
	logic [12:0] thr;
	logic [12:0] gap_g;
	logic        start_go;
	logic        new_shift;
	assign gbase = 13'(acc) + WORD_BYTES + COL_BYTES
		- (shift ? COL_BYTES : 13'h0000);
	assign ext = {3'h0, ifg_delay, 2'h0};
	assign req = (gap_adj && ext > IFG_BYTES) ? ext : IFG_BYTES;
	assign thr = dic_en ? req - 13'(DIC_MAX - deficit_idle_averaging) : req;
	assign start_go = state == S_GAP && tx_in.valid && gbase >= thr;
	assign new_shift = gbase < thr + COL_BYTES;
	assign gap_g = new_shift ? gbase : gbase - COL_BYTES;

	// deficit bookkeeping at each frame start
	always_comb begin
		next_dic = deficit_idle_averaging;
		if (gap_g < req)
			next_dic = deficit_idle_averaging + 2'(req - gap_g);
		else if (gap_g - req >= 13'(deficit_idle_averaging))
			next_dic = 2'h0;
		else
			next_dic = deficit_idle_averaging - 2'(gap_g - req);
	end

	// framing sequence
	always_comb begin
		next_state = state;
		case (state)
			S_GAP:
				if (start_go)
					next_state = S_PRE;
			S_PRE:
				next_state = (cust && !tx_in.valid) ? S_GAP : S_DATA;
			S_DATA:
				if (abort || t_here)
					next_state = S_GAP;
				else if (tx_in.last)
					next_state = S_TAIL;
			S_TAIL:
				if (t_here)
					next_state = S_GAP;
			default:
				next_state = S_GAP;
		endcase
	end

	// ready only while beats are consumed, withheld for the gap
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= S_GAP;
			tx_ready <= 1'b0;
		end else begin
			state <= next_state;
			tx_ready <= next_state == S_DATA
				|| (next_state == S_PRE && cust);
		end
	end

	// frame position, crc and frame length
	always_ff @(posedge core_clk) begin
		if (reset) begin
			base <= 16'h0000;
			len <= 16'h0000;
			crc <= CRC_INIT;
		end else begin
			base <= (state == S_PRE) ? 16'h0000 : base + 16'h0008;
			crc <= (state == S_PRE) ? CRC_INIT : crc_mid;
			if (data_ph && tx_in.last)
				len <= flen;
		end
	end

	// idle byte count since terminate, lane offset, deficit
	always_ff @(posedge core_clk) begin
		if (reset) begin
			acc <= ACC_SAT;
			shift <= 1'b0;
			deficit_idle_averaging <= 2'h0;
		end else begin
			if (t_here)
				acc <= 12'(3'h7 - tdist[2:0]);
			else if (abort || (state == S_PRE && cust && !tx_in.valid))
				acc <= 12'h000;
			else if (state == S_GAP && acc < ACC_SAT)
				acc <= acc + 12'h008;
			if (start_go) begin
				shift <= new_shift;
				deficit_idle_averaging <= dic_en ? next_dic : 2'h0;
			end
		end
	end

	// good frames counted, short in-band frames skipped
	always_ff @(posedge core_clk) begin
		if (reset)
			tx_count <= '0;
		else if (t_here && (!inband || fcs_end >= MIN_FRAME))
			tx_count <= tx_count + 1'b1;
	end

	// output stage: optional four byte delay for lane 4 starts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hold_d <= {4{XG_IDLE}};
			hold_c <= 4'hf;
			xgmii_tx <= '{data: {8{XG_IDLE}}, ctrl: 8'hff};
		end else begin
			hold_d <= aw_d[63:32];
			hold_c <= aw_c[7:4];
			xgmii_tx.data <= shift ? {aw_d[31:0], hold_d} : aw_d;
			xgmii_tx.ctrl <= shift ? {aw_c[3:0], hold_c} : aw_c;
		end
	end

	// -------------------------------------------------------------
	// receive fcs check and strip
	// -------------------------------------------------------------
	tgmac_beat_type hb;
	tgmac_beat_type next_hb;
	tgmac_beat_type next_rx;
	logic [31:0]    crc_rx;
	logic [31:0]    crc_rx_mid;
	logic [3:0]     rx_n;
	logic           rx_good;
	logic           rx_fire;

	assign rx_n = count_keep(rx_in.keep);
	assign crc_rx_mid = crc_step(crc_rx, rx_in.data, rx_in.keep);
	assign rx_good = crc_rx_mid == CRC_RESIDUE;
	assign rx_fire = rx_in.valid || (hb.valid && hb.last);

	// one beat held back so fcs lanes can be trimmed
	always_comb begin
		next_hb = hb;
		next_rx = '0;
		if (rx_fire) begin
			next_rx = hb;
			next_hb = rx_in;
			next_hb.user = rx_good;
			if (!rx_in.valid) begin
				next_hb = '0;
			end else if (rx_in.last && !rx_pass) begin
				if (rx_n > RX_FCS_N) begin
					next_hb.keep = rx_in.keep >> RX_FCS_N;
				end else begin
					next_rx.keep = hb.keep >> (RX_FCS_N - rx_n);
					next_rx.last = 1'b1;
					next_rx.user = rx_good;
					next_hb = '0;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			hb <= '0;
			rx_out <= '0;
			crc_rx <= CRC_INIT;
			rx_bad <= '0;
		end else begin
			hb <= next_hb;
			rx_out <= next_rx;
			if (rx_in.valid)
				crc_rx <= rx_in.last ? CRC_INIT : crc_rx_mid;
			if (rx_in.valid && rx_in.last && !rx_good)
				rx_bad <= rx_bad + 1'b1;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	logic odd_start;
	assign odd_start = |({xgmii_tx.ctrl[7:5], xgmii_tx.ctrl[3:1]} & {
		xgmii_tx.data[63:56] == XG_START, xgmii_tx.data[55:48] == XG_START,
		xgmii_tx.data[47:40] == XG_START, xgmii_tx.data[31:24] == XG_START,
		xgmii_tx.data[23:16] == XG_START, xgmii_tx.data[15:8] == XG_START});

	a_gap_floor: assert property (start_go |->
		gap_g >= (dic_en ? IFG_BYTES - 13'(DIC_MAX) : req))
		else $error("interframe gap too short");
	a_hold_gap: assert property (state == S_GAP |-> !tx_ready)
		else $error("ready raised during gap");
	a_start_lane: assert property (!odd_start)
		else $error("start not on four byte boundary");
	a_dic_bound: assert property (start_go && !dic_en |=>
		deficit_idle_averaging == 2'h0 && state == S_PRE)
		else $error("deficit used while averaging off");
	a_pad_min: assert property (t_here && !inband |->
		fcs_end >= MIN_FRAME)
		else $error("short frame not padded");
	a_no_pad: assert property (t_here && inband |-> fcs_end == flen)
		else $error("in-band frame padded");
	a_stat_skip: assert property (t_here && inband
		&& fcs_end < MIN_FRAME |=> tx_count == $past(tx_count))
		else $error("short in-band frame counted");
	a_abort_err: assert property (data_ph && tx_in.valid
		&& tx_in.user |-> aw_d[7:0] == XG_ERR ##1 state == S_GAP)
		else $error("explicit abort not flagged");
	a_implicit_err: assert property (data_ph && !tx_in.valid |->
		aw_c == 8'hff ##1 (state == S_GAP && acc == 12'h000 && !tx_ready))
		else $error("implicit underrun not flagged");
	a_rx_bad: assert property (rx_in.valid && rx_in.last && !rx_good
		|-> ##[1:2] (rx_out.valid && rx_out.last && !rx_out.user))
		else $error("bad fcs not reported");
	a_rx_strip: assert property (rx_in.valid && rx_in.last && !rx_pass
		&& rx_n > RX_FCS_N |-> ##2 (rx_out.last
		&& rx_out.keep == ($past(rx_in.keep, 2) >> RX_FCS_N)))
		else $error("fcs lanes not stripped");
	a_apb_ready: assert property (setup |=> pready && !$past(penable))
		else $error("apb answer late");

	c_lane4: cover property (start_go && new_shift);
	c_abort: cover property (abort);
	c_rx_short: cover property (rx_in.valid && rx_in.last && !rx_pass
		&& rx_n <= RX_FCS_N);
	c_dic: cover property (start_go && dic_en && gap_g < req);
endmodule

// ==== inc/tgmac_pkg.sv ====
// constants and carrier types of the 10G mac transmit client path
// assumes a single core clock domain shared by all users
package tgmac_pkg;
	// -------------------------------------------------------------
	// stream and xgmii coding
	// -------------------------------------------------------------
	localparam int LANES = 8;
	localparam logic [7:0] XG_IDLE = 8'h07;
	localparam logic [7:0] XG_START = 8'hfb;
	localparam logic [7:0] XG_TERM = 8'hfd;
	localparam logic [7:0] XG_ERR = 8'hfe;
	localparam logic [7:0] PRE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [63:0] ERR_DATA = {XG_TERM, {7{XG_ERR}}};
	// -------------------------------------------------------------
	// frame check sequence, reflected form
	// -------------------------------------------------------------
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	localparam logic [15:0] FCS_BYTES = 16'h0004;
	localparam logic [15:0] MIN_NOFCS = 16'h003c;
	localparam logic [15:0] MIN_FRAME = 16'h0040;
	localparam logic [3:0] RX_FCS_N = 4'h4;
	// -------------------------------------------------------------
	// interframe gap, in bytes (96 bit times is 12 bytes)
	// -------------------------------------------------------------
	localparam logic [12:0] IFG_BYTES = 13'h000c;
	localparam logic [12:0] COL_BYTES = 13'h0004;
	localparam logic [12:0] WORD_BYTES = 13'h0008;
	localparam logic [11:0] ACC_SAT = 12'h7ff;
	localparam logic [1:0] DIC_MAX = 2'h3;
	// -------------------------------------------------------------
	// apb register map
	// -------------------------------------------------------------
	localparam logic [7:0] CFG_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam int CFG_W = 5;
	localparam int CFG_TX_INBAND = 0;
	localparam int CFG_DIC = 1;
	localparam int CFG_GAP_ADJ = 2;
	localparam int CFG_RX_PASS = 3;
	localparam int CFG_CUST_PRE = 4;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
	// -------------------------------------------------------------
	// carriers
	// -------------------------------------------------------------
	typedef struct packed {
		logic [63:0] data;
		logic [7:0]  ctrl;
	} tgmac_xgmii_type;
	typedef struct packed {
		logic        valid;
		logic [63:0] data;
		logic [7:0]  keep;
		logic        last;
		logic        user;
	} tgmac_beat_type;
endpackage

// ==== tb/tgmac_client_model.sv ====
// client stream source standing in for a transmit fifo
// assumes core_clk domain; frame bytes count up from lane 0 of beat 0
module tgmac_client_model (
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 go,
	input  wire logic [15:0]          len,
	input  wire logic [3:0]           nframes,
	input  wire logic [1:0]           abort_kind,
	input  wire logic                 tx_ready,
	output tgmac_pkg::tgmac_beat_type tx_in,
	output logic                      busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import tgmac_pkg::*;
	logic [15:0] pos;
	logic [3:0]  left;
	logic [15:0] nxt;
	logic        stop;
	logic        ab_now;

	// beat builder: lane n carries frame byte p+n
	function automatic tgmac_beat_type beat(input logic [15:0] p,
		input logic [15:0] l);
		tgmac_beat_type bt;
		bt = '0;
		bt.valid = 1'b1;
		for (int n = 0; n < LANES; n++) begin
			bt.data[8*n+:8] = p[7:0] + 8'(n);
			bt.keep[n] = (p + 16'(n)) < l;
		end
		bt.last = (p + 16'h0008) >= l;
		return bt;
	endfunction

	// abort point is the third beat of a frame
	assign nxt = pos + 16'h0008;
	assign stop = (abort_kind == 2'h2) && (nxt == 16'h0010);
	assign ab_now = (abort_kind == 2'h1) && (nxt == 16'h0010);

	// stream sequencing, moves only on an accepted beat
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_in <= '0;
			busy <= 1'b0;
			pos <= '0;
			left <= '0;
		end else if (go && !busy) begin
			busy <= 1'b1;
			pos <= '0;
			left <= nframes;
			tx_in <= beat(16'h0000, len);
		end else if (busy && tx_in.valid && tx_ready) begin
			if (tx_in.last && left > 4'h1 && abort_kind == 2'h0) begin
				left <= left - 4'h1;
				pos <= '0;
				tx_in <= beat(16'h0000, len);
			end else if (tx_in.last || tx_in.user || stop) begin
				busy <= 1'b0;
				tx_in.valid <= 1'b0;
				tx_in.data <= ~tx_in.data;
			end else begin
				pos <= nxt;
				tx_in <= beat(nxt, len);
				tx_in.user <= ab_now;
			end
		end else if (!busy) begin
			tx_in.data <= ~tx_in.data; // released lines keep moving
			tx_in.keep <= ~tx_in.keep;
		end
	end
endmodule

// ==== tb/tenge_mac_transmit_client_path_bench.sv ====
// self-checking bench for the 10G mac transmit client path
// assumes client model on the stream; bench drives apb and the rx side
module tenge_mac_transmit_client_path_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import tgmac_pkg::*;
	logic            core_clk = 1'b0;
	logic            reset = 1'b1;
	logic [7:0]      paddr = '0;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [31:0]     pwdata = '0;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            tx_ready;
	logic [7:0]      ifg_delay = '0;
	logic            go = 1'b0;
	logic [15:0]     len = '0;
	logic [3:0]      nframes = '0;
	logic [1:0]      abort_kind = '0;
	logic            busy;
	tgmac_beat_type  tx_in;
	tgmac_beat_type  rx_in = '0;
	tgmac_beat_type  rx_out;
	tgmac_xgmii_type xgmii_tx;
	int              n_fail = 0;
	int              samples_checked = 0;
	int              nfr = 0;
	int              idl = 0;
	int              gap = 0;
	int              gmin = 0;
	int              slane = 0;
	int              exp_tx = 0;
	int              exp_rxbad = 0;
	logic            infr = 1'b0;
	logic            merr = 1'b0;
	logic [7:0]      mq[$];
	logic [7:0]      b;
	logic [31:0]     rd;
	logic            er;

	always #5 core_clk = ~core_clk;

	tgmac_tx DUT (
		.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_in(tx_in), .tx_ready(tx_ready), .ifg_delay(ifg_delay),
		.xgmii_tx(xgmii_tx), .rx_in(rx_in), .rx_out(rx_out)
	);
	tgmac_client_model client_model (
		.core_clk(core_clk), .reset(reset), .go(go), .len(len),
		.nframes(nframes), .abort_kind(abort_kind), .tx_ready(tx_ready),
		.tx_in(tx_in), .busy(busy)
	);

	// ----------
	// xgmii monitor: frame bytes, gap and start lane
	// ----------
	// sampled mid-cycle, where the registered word has settled
	always @(negedge core_clk) begin
		for (int n = 0; n < LANES; n++) begin
			b = xgmii_tx.data[8*n+:8];
			if (xgmii_tx.ctrl[n] && b == XG_START) begin
				infr = 1'b1;
				mq = {};
				gap = idl + 1;
				gmin = (gap < gmin) ? gap : gmin;
				idl = 0;
				slane = n;
				merr = 1'b0;
			end else if (infr && !xgmii_tx.ctrl[n]) begin
				mq.push_back(b);
			end else if (infr) begin
				infr = 1'b0;
				merr = (b == XG_ERR);
				nfr++;
			end else if (xgmii_tx.ctrl[n] && b == XG_IDLE) begin
				idl++;
			end
		end
	end

	// ----------
	// shared tasks
	// ----------
	task automatic finish_test(input logic hung);
		if (hung)
			n_fail++;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	function automatic logic [31:0] fcs(input logic [7:0] q[$], input int s,
		input int n);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = s; i < s + n; i++) begin
			c = c ^ {24'h0, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
			finish_test(1'b1);
	endtask

	task automatic send(input int l, input int nf, input int ab);
		int i;
		int t;
		t = nfr + nf;
		@(posedge core_clk);
		len <= 16'(l);
		nframes <= 4'(nf);
		abort_kind <= 2'(ab);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (i = 0; i < 900; i++) begin
			@(negedge core_clk);
			if (nfr >= t && !busy)
				break;
		end
		if (i == 900)
			finish_test(1'b1);
	endtask

	task automatic frame_chk(input int cl, input int wl, input logic ib);
		int e;
		e = wl + 3;
		cmp("sfd", SFD_BYTE, mq[6]);
		cmp("frame_len", wl, mq.size() - 7);
		for (int i = 0; i < cl; i++)
			cmp("frame_byte", i % 256, mq[7 + i]);
		if (!ib)
			cmp("fcs", fcs(mq, 7, wl - 4),
				{mq[e+3], mq[e+2], mq[e+1], mq[e]});
		cmp("frame_err", 0, merr);
		cmp("start_lane", 1, slane % 4 == 0);
	endtask

	// ----------
	// scenarios
	// ----------
	task automatic t_reset;
		@(negedge core_clk);
		cmp("ready_rst", 0, tx_ready);
		cmp("xgmii_rst", 32'hff070707,
			{xgmii_tx.ctrl, xgmii_tx.data[23:0]});
		cmp("rx_rst", 0, rx_out.valid);
	endtask

	task automatic t_regs;
		apb(1'b0, CFG_ADDR, 32'h0, rd, er);
		cmp("cfg_reset", 32'h0, rd);
		apb(1'b1, CFG_ADDR, 32'hffffffff, rd, er);
		apb(1'b0, CFG_ADDR, 32'h0, rd, er);
		cmp("cfg_bits", 32'h1f, rd);
		cmp("cfg_err", 32'h0, er);
		apb(1'b1, STAT_ADDR, 32'hffffffff, rd, er);
		apb(1'b0, STAT_ADDR, 32'h0, rd, er);
		cmp("stat_ro", 32'h0, rd);
		apb(1'b0, 8'h08, 32'h0, rd, er);
		cmp("unmapped", 32'h1, er);
		apb(1'b1, CFG_ADDR, 32'h0, rd, er);
	endtask

	task automatic t_pad;
		int ln[4] = '{20, 59, 60, 100};
		foreach (ln[k]) begin
			send(ln[k], 1, 0);
			frame_chk(ln[k], (ln[k] < 60 ? 60 : ln[k]) + 4, 0);
			exp_tx++;
		end
	endtask

	task automatic t_inband;
		apb(1'b1, CFG_ADDR, 32'h1, rd, er);
		send(20, 1, 0);
		frame_chk(20, 20, 1);
		send(64, 1, 0);
		frame_chk(64, 64, 1);
		exp_tx++;
	endtask

	task automatic t_gap;
		int cf[4] = '{0, 4, 4, 2};
		int dl[4] = '{0, 1, 10, 0};
		int mn[4] = '{12, 12, 40, 9};
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, CFG_ADDR, 32'(cf[k]), rd, er);
			ifg_delay <= 8'(dl[k]);
			gmin = 999;
			send(61, 3, 0);
			cmp("gap", 1, gmin >= mn[k]);
			frame_chk(61, 65, 0);
			exp_tx += 3;
		end
	endtask

	task automatic t_abort;
		apb(1'b1, CFG_ADDR, 32'h0, rd, er);
		for (int ab = 1; ab < 3; ab++) begin
			send(64, 1, ab);
			cmp("underrun", 1, merr);
			send(64, 1, 0);
			frame_chk(64, 68, 0);
			exp_tx++;
		end
	endtask

	task automatic t_rx;
		logic [7:0] q[$];
		logic [63:0] d;
		int i;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, CFG_ADDR, {28'h0, m[1], 3'h0}, rd, er);
			q = {};
			for (i = 0; i < 12; i++)
				q.push_back(8'h30 + 8'(i));
			d[31:0] = fcs(q, 0, 12);
			for (i = 0; i < 4; i++)
				q.push_back(d[8*i+:8]);
			q[0] = q[0] ^ {7'h0, m[0]};
			for (int h = 0; h < 2; h++) begin
				for (i = 0; i < 8; i++)
					d[8*i+:8] = q[8*h+i];
				@(posedge core_clk);
				rx_in <= '{1'b1, d, 8'hff, h[0], 1'b0};
			end
			@(posedge core_clk);
			rx_in.valid <= 1'b0;
			rx_in.data <= ~d;
			for (i = 0; i < 20; i++) begin
				@(negedge core_clk);
				if (rx_out.valid && rx_out.last)
					break;
			end
			if (i == 20)
				finish_test(1'b1);
			cmp("rx_keep", m[1] ? 32'hff : 32'h0f, rx_out.keep);
			cmp("rx_data", {q[11], q[10], q[9], q[8]},
				rx_out.data[31:0]);
			cmp("rx_good", !m[0], rx_out.user);
			exp_rxbad += m[0];
		end
	endtask

	task automatic t_stat;
		apb(1'b0, STAT_ADDR, 32'h0, rd, er);
		cmp("stat", {exp_rxbad[15:0], exp_tx[15:0]}, rd);
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		t_reset;
		t_regs;
		t_pad;
		t_inband;
		t_gap;
		t_abort;
		t_rx;
		t_stat;
		finish_test(1'b0);
	end
endmodule
